// ### rtl/dbg_access_pkg.sv
// Shared constants for the debug access system registers
package dbg_access_pkg;

  // ----------------------------------------------------------------
  // Link register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_RESET_REQ   = 4'h8;
  localparam logic [3:0] OFF_CLOCK_SEL   = 4'h9;
  localparam logic [3:0] OFF_SYS_CONTROL = 4'ha;
  localparam logic [3:0] OFF_SYS_STATUS  = 4'hb;
  localparam logic [3:0] OFF_CRC_STATUS  = 4'hc;

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_SIGNATURE  = 8'h59;
  localparam int         BIT_CLOCK_REQ    = 0;
  localparam int         BIT_UROW_FINAL   = 1;
  localparam int         BIT_LOCKED       = 0;
  localparam int         BIT_UROW_ALLOWED = 2;
  localparam int         BIT_NVM_ALLOWED  = 3;
  localparam int         BIT_IN_SLEEP     = 4;
  localparam int         BIT_RESET_ACTIVE = 5;

  localparam logic [1:0] CLKSEL_RESERVED = 2'h0;
  localparam logic [1:0] CLKSEL_16MHZ    = 2'h1;
  localparam logic [1:0] CLKSEL_8MHZ     = 2'h2;
  localparam logic [1:0] CLKSEL_4MHZ     = 2'h3;
  localparam logic [1:0] CLKSEL_RESET    = CLKSEL_4MHZ;

  localparam logic [2:0] CRC_OFF       = 3'h0;
  localparam logic [2:0] CRC_BUSY      = 3'h1;
  localparam logic [2:0] CRC_DONE_OK   = 3'h2;
  localparam logic [2:0] CRC_DONE_FAIL = 3'h4;

  // Synchroniser reset: locked bit (index 6) starts high
  localparam logic [9:0] SYNC_RESET = 10'h040;

  // ----------------------------------------------------------------
  // Controller command registers
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_TARGET  = 2'h0;
  localparam logic [1:0] CMD_DATA    = 2'h1;
  localparam logic [1:0] CMD_CONTROL = 2'h2;
  localparam logic [1:0] CMD_STATUS  = 2'h3;
  localparam int         CTL_GO_WRITE = 0;
  localparam int         CTL_GO_READ  = 1;
  localparam int         CTL_FAST_OK  = 2;
  localparam int         STS_BUSY     = 0;
  localparam int         STS_DONE     = 1;

endpackage : dbg_access_pkg

// ### rtl/dbg_access_if.sv
// Register link between debug controller and device access layer
`timescale 1ns/100ps
interface dbg_access_if;
  logic       link_wr;
  logic       link_rd;
  logic [3:0] link_addr;
  logic [7:0] link_wdata;
  logic [7:0] link_rdata;

  modport device (input link_wr, link_rd, link_addr, link_wdata, output link_rdata);
  modport host   (output link_wr, link_rd, link_addr, link_wdata, input link_rdata);
endinterface : dbg_access_if

// ### rtl/dbg_access_regs.sv
// Device end: access layer system control and status registers
// Operation
// RULE1 - Signature write holds system reset
// RULE2 - Other value write releases held reset
// RULE3 - Read bit0 shows held reset, rest zero
// RULE4 - System reset leaves debug logic intact
// RULE5 - Clock select codes 16/8/4 MHz, default 4
// RULE6 - Debugger keeps 4 MHz unless brown-out highest
// RULE7 - User row final write starts programming
// RULE8 - User row final needs decoded key
// RULE9 - Debugger fills RAM before final bit
// RULE10 - Clock request bit requests system clock
// RULE11 - Clock request set on enable, cleared disable
// RULE12 - Reset active status, cleared on read
// RULE13 - In-sleep status while system sleeps
// RULE14 - NVM programming allowed, then reset system
// RULE15 - User row allowed status, then final bit
// RULE16 - Lock status reads one while locked
// RULE17 - CRC status one-hot scan state
// RULE18 - Registers reachable only over debug link
// RULE19 - Disable drops clock request, resets logic
// RULE20 - Reserved clock code keeps previous selection
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
module dbg_access_regs (
  // Clock and reset
  input  wire logic                   SYS_CLK,
  input  wire logic                   RESETN,
  // Debug link
  dbg_access_if.device                LINK,
  // System side status, asynchronous to this clock
  input  wire logic                   DEBUG_DISABLE,
  input  wire logic                   SYSTEM_IN_RESET,
  input  wire logic                   SYSTEM_IN_SLEEP,
  input  wire logic                   NVM_PROGRAMMING_ALLOWED,
  input  wire logic                   USER_ROW_PROGRAMMING_ALLOWED,
  input  wire logic                   USER_ROW_WRITE_KEY,
  input  wire logic                   DEVICE_LOCKED,
  input  wire logic [2:0]             CRC_SCAN_STATE,
  // System side controls
  output logic                        SYSTEM_RESET_HOLD,
  output logic                        SYSTEM_CLOCK_REQUEST,
  output logic [1:0]                  DEBUG_CLOCK_SELECT,
  output logic                        USER_ROW_FINAL_START
);
  import dbg_access_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0] sync_a;
    logic [9:0] sync_b;
    logic       disabled_prev;
    logic       reset_hold;
    logic [1:0] clock_sel;
    logic       clock_req;
    logic       urow_start;
    logic       reset_seen;
    logic [7:0] rdata;
  } state_s;

  state_s st;
  state_s next_st;

  // Synchronised status, second stage only
  logic       s_disable;
  logic       s_sys_reset;
  logic       s_sleep;
  logic       s_nvm_ok;
  logic       s_urow_ok;
  logic       s_urow_key;
  logic       s_locked;
  logic [2:0] s_crc;

  assign s_disable   = st.sync_b[0];
  assign s_sys_reset = st.sync_b[1];
  assign s_sleep     = st.sync_b[2];
  assign s_nvm_ok    = st.sync_b[3];
  assign s_urow_ok   = st.sync_b[4];
  assign s_urow_key  = st.sync_b[5];
  assign s_locked    = st.sync_b[6];
  assign s_crc       = st.sync_b[9:7];

  // Access decode; only the debug link reaches these registers [RULE18]
  logic wr_reset;
  logic wr_clock;
  logic wr_control;
  logic rd_status;

  assign wr_reset   = LINK.link_wr && (LINK.link_addr == OFF_RESET_REQ);
  assign wr_clock   = LINK.link_wr && (LINK.link_addr == OFF_CLOCK_SEL);
  assign wr_control = LINK.link_wr && (LINK.link_addr == OFF_SYS_CONTROL);
  assign rd_status  = LINK.link_rd && (LINK.link_addr == OFF_SYS_STATUS);

  // Live system reset view, including our own hold
  logic reset_now;
  assign reset_now = s_sys_reset || st.reset_hold;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st            = st;
    next_st.sync_a     = {CRC_SCAN_STATE, DEVICE_LOCKED, USER_ROW_WRITE_KEY,
                          USER_ROW_PROGRAMMING_ALLOWED, NVM_PROGRAMMING_ALLOWED,
                          SYSTEM_IN_SLEEP, SYSTEM_IN_RESET, DEBUG_DISABLE};
    next_st.sync_b     = st.sync_a;
    next_st.disabled_prev = s_disable;
    next_st.urow_start = 1'b0;
    next_st.rdata      = 8'h00;

    if (s_disable) begin
      // Disabled: all configuration back to defaults, request lowered [RULE19]
      next_st.reset_hold = 1'b0;
      next_st.clock_sel  = CLKSEL_RESET;
      next_st.clock_req  = 1'b0; // [RULE11]
      next_st.reset_seen = 1'b0;
    end else begin
      if (st.disabled_prev) begin
        next_st.clock_req = 1'b1; // [RULE11]
      end

      // Reset request register
      if (wr_reset) begin
        if (LINK.link_wdata == RESET_SIGNATURE) begin
          next_st.reset_hold = 1'b1; // [RULE1]
        end else begin
          next_st.reset_hold = 1'b0; // [RULE2]
        end
      end

      // Clock select; reserved code leaves selection alone
      if (wr_clock && (LINK.link_wdata[1:0] != CLKSEL_RESERVED)) begin // [RULE20]
        next_st.clock_sel = LINK.link_wdata[1:0]; // [RULE5]
      end

      // System control
      if (wr_control) begin
        next_st.clock_req = LINK.link_wdata[BIT_CLOCK_REQ]; // [RULE10]
        if (s_urow_key && LINK.link_wdata[BIT_UROW_FINAL]) begin // [RULE8]
          next_st.urow_start = 1'b1; // [RULE7] [RULE15]
        end
      end

      // Sticky reset seen; a reset present in the read cycle survives [RULE12]
      if (rd_status) begin
        next_st.reset_seen = reset_now;
      end else if (reset_now) begin
        next_st.reset_seen = 1'b1;
      end

      // Read data, valid the cycle after the read strobe
      if (LINK.link_rd) begin
        case (LINK.link_addr)
          OFF_RESET_REQ: begin
            next_st.rdata = {7'h00, st.reset_hold}; // [RULE3]
          end
          OFF_CLOCK_SEL: begin
            next_st.rdata = {6'h00, st.clock_sel};
          end
          OFF_SYS_CONTROL: begin
            next_st.rdata = {7'h00, st.clock_req};
          end
          OFF_SYS_STATUS: begin
            next_st.rdata[BIT_RESET_ACTIVE] = st.reset_seen || reset_now; // [RULE12]
            next_st.rdata[BIT_IN_SLEEP]     = s_sleep;   // [RULE13]
            next_st.rdata[BIT_NVM_ALLOWED]  = s_nvm_ok;  // [RULE14]
            next_st.rdata[BIT_UROW_ALLOWED] = s_urow_ok; // [RULE15]
            next_st.rdata[BIT_LOCKED]       = s_locked;  // [RULE16]
          end
          OFF_CRC_STATUS: begin
            next_st.rdata = {5'h00, s_crc}; // [RULE17]
          end
          default: begin
            next_st.rdata = 8'h00;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Only RESETN and the disable input clear this logic; the system
  // reset we drive never loops back here [RULE4]
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st.sync_a        <= SYNC_RESET;
      st.sync_b        <= SYNC_RESET;
      st.disabled_prev <= 1'b0;
      st.reset_hold    <= 1'b0;
      st.clock_sel     <= CLKSEL_RESET; // [RULE5]
      st.clock_req     <= 1'b1;         // [RULE11]
      st.urow_start    <= 1'b0;
      st.reset_seen    <= 1'b0;
      st.rdata         <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign LINK.link_rdata          = st.rdata;
  assign SYSTEM_RESET_HOLD    = st.reset_hold;
  assign SYSTEM_CLOCK_REQUEST = st.clock_req;
  assign DEBUG_CLOCK_SELECT   = st.clock_sel;
  assign USER_ROW_FINAL_START = st.urow_start;

endmodule : dbg_access_regs

// ### rtl/dbg_access_host.sv
// Controller end: issues link accesses ordered through command registers
`timescale 1ns/100ps
module dbg_access_host (
  // Clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RESETN,
  // Command port
  input  wire logic [1:0] CMD_ADDR,
  input  wire logic [7:0] CMD_WDATA,
  input  wire logic       CMD_WR,
  input  wire logic       CMD_RD,
  output logic      [7:0] CMD_RDATA,
  // Debug link
  dbg_access_if.host      LINK
);
  import dbg_access_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IDLE    = 2'b00,
    STROBE  = 2'b01,
    CAPTURE = 2'b10
  } phase_e;

  typedef struct packed {
    phase_e     phase;
    logic [3:0] target;
    logic [7:0] data;
    logic       fast_ok;
    logic       done;
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } state_s;

  state_s st;
  state_s next_st;

  logic go_wr;
  logic go_rd;
  assign go_wr = CMD_WR && (CMD_ADDR == CMD_CONTROL) && CMD_WDATA[CTL_GO_WRITE];
  assign go_rd = CMD_WR && (CMD_ADDR == CMD_CONTROL) && CMD_WDATA[CTL_GO_READ];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.wr    = 1'b0;
    next_st.rd    = 1'b0;
    next_st.rdata = 8'h00;

    if (CMD_WR && (st.phase == IDLE)) begin
      case (CMD_ADDR)
        CMD_TARGET:  next_st.target = CMD_WDATA[3:0];
        CMD_DATA:    next_st.data   = CMD_WDATA;
        CMD_CONTROL: next_st.fast_ok = CMD_WDATA[CTL_FAST_OK];
        default:     next_st.target = st.target;
      endcase
    end

    case (st.phase)
      IDLE: begin
        // One access at a time, issued in command order [RULE9]
        if (go_wr || go_rd) begin
          next_st.phase = STROBE;
          next_st.done  = 1'b0;
          next_st.addr  = st.target;
          next_st.wdata = st.data;
          next_st.wr    = go_wr;
          next_st.rd    = go_rd && !go_wr;
          // Without the highest brown-out level only 4 MHz is sent [RULE6]
          // Permission comes from this same control write, not the stored copy
          if (go_wr && !CMD_WDATA[CTL_FAST_OK] && (st.target == OFF_CLOCK_SEL)) begin
            next_st.wdata = {st.data[7:2], CLKSEL_4MHZ};
          end
        end
      end
      STROBE: begin
        next_st.phase = st.rd ? CAPTURE : IDLE;
        next_st.done  = !st.rd;
      end
      CAPTURE: begin
        next_st.data  = LINK.link_rdata;
        next_st.done  = 1'b1;
        next_st.phase = IDLE;
      end
      default: begin
        next_st.phase = IDLE;
      end
    endcase

    if (CMD_RD) begin
      case (CMD_ADDR)
        CMD_TARGET:  next_st.rdata = {4'h0, st.target};
        CMD_DATA:    next_st.rdata = st.data;
        CMD_CONTROL: next_st.rdata = {5'h00, st.fast_ok, 2'b00};
        CMD_STATUS:  next_st.rdata = {6'h00, st.done, (st.phase != IDLE)};
        default:     next_st.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st <= '{phase: IDLE, target: 4'h0, data: 8'h00, fast_ok: 1'b0, done: 1'b0,
              wr: 1'b0, rd: 1'b0, addr: 4'h0, wdata: 8'h00, rdata: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign LINK.link_wr    = st.wr;
  assign LINK.link_rd    = st.rd;
  assign LINK.link_addr  = st.addr;
  assign LINK.link_wdata = st.wdata;
  assign CMD_RDATA       = st.rdata;

endmodule : dbg_access_host

// ### tb/dbg_access_asserts.sv
// Link protocol and register readback checks
`timescale 1ns/100ps
module dbg_access_asserts (
  // Clock and reset
  input wire logic       SYS_CLK,
  input wire logic       RESETN,
  // Link signals
  input wire logic       link_wr,
  input wire logic       link_rd,
  input wire logic [3:0] link_addr,
  input wire logic [7:0] link_wdata,
  input wire logic [7:0] link_rdata
);
  import dbg_access_pkg::*;
  // Mirror of the signature hold; disable is never raised while it is set
  logic sig_held;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sig_held <= 1'b0;
    end else if (link_wr && link_addr == OFF_RESET_REQ) begin
      sig_held <= (link_wdata == RESET_SIGNATURE);
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  a_strobe_excl: assert property (
    !(link_wr && link_rd)) else $error("link strobes overlap");
  a_rdata_idle: assert property (
    !link_rd |=> link_rdata == 8'h00) else $error("read data without read");
  a_hold_readback: assert property (
    link_rd && link_addr == OFF_RESET_REQ |=> link_rdata == {7'h00, sig_held})
    else $error("reset request readback wrong");
  a_clksel_code: assert property (
    link_rd && link_addr == OFF_CLOCK_SEL |=> link_rdata[7:2] == 6'h00
    && link_rdata[1:0] != CLKSEL_RESERVED) else $error("clock select readback bad");
  a_ctrl_read: assert property (
    link_rd && link_addr == OFF_SYS_CONTROL |=> link_rdata[7:1] == 7'h00)
    else $error("control upper bits set");
  a_status_bits: assert property (
    link_rd && link_addr == OFF_SYS_STATUS |=> link_rdata[7:6] == 2'h0
    && !link_rdata[1]) else $error("status reserved bits set");
  a_crc_onehot: assert property (
    link_rd && link_addr == OFF_CRC_STATUS |=> link_rdata[7:3] == 5'h00
    && $onehot0(link_rdata[2:0])) else $error("crc status not one-hot");
  a_wr_pulse: assert property (
    link_wr |=> !link_wr) else $error("write strobe too long");
endmodule : dbg_access_asserts

// ### tb/debug_access_system_regs_tb_top.sv
// Bench joining controller and device ends over the register link
`timescale 1ns/100ps
module debug_access_system_regs_tb_top;
  import dbg_access_pkg::*;
  logic       SYS_CLK, RESETN, cmd_wr, cmd_rd, dis, rst, slp, nvm, uok, key, lck;
  logic [1:0] cmd_addr, sel, code;
  logic [7:0] cmd_wdata, cmd_rdata, got, v;
  logic [2:0] crc;
  logic       hold, creq, start, fast;
  logic [1:0] csel;
  int         n_mismatch, checked, seed, n_start, n0;
  logic [3:0] offs [6] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'h5};
  logic [7:0] rexp [6] = '{8'h00, 8'h03, 8'h01, 8'h01, 8'h00, 8'h00};
  logic [2:0] ctab [4] = '{CRC_OFF, CRC_BUSY, CRC_DONE_OK, CRC_DONE_FAIL};
  dbg_access_if dbg_access_if_i ();
  dbg_access_regs dbg_access_regs_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
    .LINK(dbg_access_if_i.device), .DEBUG_DISABLE(dis), .SYSTEM_IN_RESET(rst),
    .SYSTEM_IN_SLEEP(slp), .NVM_PROGRAMMING_ALLOWED(nvm),
    .USER_ROW_PROGRAMMING_ALLOWED(uok), .USER_ROW_WRITE_KEY(key),
    .DEVICE_LOCKED(lck), .CRC_SCAN_STATE(crc), .SYSTEM_RESET_HOLD(hold),
    .SYSTEM_CLOCK_REQUEST(creq), .DEBUG_CLOCK_SELECT(csel),
    .USER_ROW_FINAL_START(start));
  dbg_access_host dbg_access_host_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
    .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .CMD_WR(cmd_wr), .CMD_RD(cmd_rd),
    .CMD_RDATA(cmd_rdata), .LINK(dbg_access_if_i.host));
  dbg_access_asserts dbg_access_asserts_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
    .link_wr(dbg_access_if_i.link_wr), .link_rd(dbg_access_if_i.link_rd),
    .link_addr(dbg_access_if_i.link_addr), .link_wdata(dbg_access_if_i.link_wdata),
    .link_rdata(dbg_access_if_i.link_rdata));
  always #5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    if (start === 1'b1) n_start++;
  end
  task automatic print_verdict();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  // Expected clock code after a write of code c with fast permission f
  function automatic logic [1:0] exp_sel(input logic [1:0] prev, input logic [1:0] c,
                                         input logic f);
    if (!f) return CLKSEL_4MHZ;
    return (c == CLKSEL_RESERVED) ? prev : c;
  endfunction : exp_sel
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One command port access; read data is taken in the cycle after the strobe
  task automatic cmd(input logic [1:0] a, input logic [7:0] d, input logic rd);
    @(posedge SYS_CLK);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= !rd;
    cmd_rd <= rd;
    @(posedge SYS_CLK);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    #1 got = cmd_rdata;
  endtask : cmd
  task automatic link(input logic [3:0] off, input logic [7:0] d, input logic rd,
                      input logic fst);
    int i;
    cmd(CMD_TARGET, {4'h0, off}, 1'b0);
    if (!rd) cmd(CMD_DATA, d, 1'b0);
    cmd(CMD_CONTROL, {5'h00, fst, rd, !rd}, 1'b0);
    for (i = 0; i < 20; i++) begin
      cmd(CMD_STATUS, 8'h00, 1'b1);
      if (got[STS_BUSY] === 1'b0) break;
    end
    if (i == 20) begin
      n_mismatch++;
      print_verdict();
    end
    if (rd) cmd(CMD_DATA, 8'h00, 1'b1);
  endtask : link
  // Read system status and compare the reset-active bit
  task automatic rst_bit(input logic exp);
    link(OFF_SYS_STATUS, 8'h00, 1'b1, 1'b0);
    check(8'(got[BIT_RESET_ACTIVE]), 8'(exp));
  endtask : rst_bit
  initial begin
    {SYS_CLK, RESETN, cmd_wr, cmd_rd, dis, rst, slp, nvm, uok, key} = '0;
    {cmd_addr, cmd_wdata, crc} = '0;
    lck = 1'b1;
    seed = 37;
    repeat (6) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    foreach (offs[k]) begin
      link(offs[k], 8'h00, 1'b1, 1'b0);
      check(got, rexp[k]);
    end
    // Every code with fast allowed first, then random codes and permission
    sel = CLKSEL_RESET;
    for (int k = 0; k < 10; k++) begin
      code = (k < 4) ? 2'(k) : 2'($random(seed));
      fast = (k < 4) ? 1'b1 : 1'($random(seed));
      link(OFF_CLOCK_SEL, {6'h00, code}, 1'b0, fast);
      sel = exp_sel(sel, code, fast);
      check(8'(csel), 8'(sel));
      link(OFF_CLOCK_SEL, 8'h00, 1'b1, fast);
      check(got, 8'(sel));
    end
    link(OFF_RESET_REQ, RESET_SIGNATURE, 1'b0, 1'b0);
    check(8'(hold), 8'h01);
    link(OFF_RESET_REQ, 8'h00, 1'b1, 1'b0);
    check(got, 8'h01);
    check(8'({creq, csel}), 8'({1'b1, sel}));
    rst_bit(1'b1);
    v = 8'($random(seed));
    if (v == RESET_SIGNATURE) v = 8'h00;
    link(OFF_RESET_REQ, v, 1'b0, 1'b0);
    check(8'(hold), 8'h00);
    rst_bit(1'b1);
    rst_bit(1'b0);
    rst <= 1'b1;
    rst_bit(1'b1);
    rst <= 1'b0;
    rst_bit(1'b1);
    rst_bit(1'b0);
    link(OFF_SYS_CONTROL, 8'h00, 1'b0, 1'b0);
    check(8'(creq), 8'h00);
    link(OFF_SYS_CONTROL, 8'h00, 1'b1, 1'b0);
    check(got, 8'h00);
    n0 = n_start;
    link(OFF_SYS_CONTROL, 8'h03, 1'b0, 1'b0);
    check(8'(n_start - n0), 8'h00);
    check(8'(creq), 8'h01);
    key <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    link(OFF_SYS_CONTROL, 8'h03, 1'b0, 1'b0);
    check(8'(n_start - n0), 8'h01);
    for (int k = 0; k < 8; k++) begin
      {slp, nvm, uok, lck} <= (k == 0) ? 4'h0 : 4'($random(seed));
      crc <= ctab[(k < 4) ? k : 2'($random(seed))];
      repeat (4) @(posedge SYS_CLK);
      link(OFF_SYS_STATUS, 8'h00, 1'b1, 1'b0);
      check(got, {3'h0, slp, nvm, uok, 1'b0, lck});
      link(OFF_CRC_STATUS, 8'h00, 1'b1, 1'b0);
      check(got, {5'h00, crc});
    end
    link(OFF_CLOCK_SEL, {6'h00, CLKSEL_8MHZ}, 1'b0, 1'b1);
    dis <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    check(8'({creq, csel}), 8'({1'b0, CLKSEL_RESET}));
    link(OFF_RESET_REQ, 8'h00, 1'b1, 1'b0);
    check(got, 8'h00);
    dis <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    check(8'(creq), 8'h01);
    link(OFF_CLOCK_SEL, 8'h00, 1'b1, 1'b0);
    check(got, 8'(CLKSEL_RESET));
    print_verdict();
  end
endmodule : debug_access_system_regs_tb_top
